/* File: capture_timer_pkg.sv */
// Constants, field layout and codes of the input-capture timer.
// Assumes a 32-bit APB slave with word-aligned registers.
package capture_timer_pkg;

	// ==========================================================
	// Bus and data widths
	localparam int ADDR_W = 18;
	localparam int DATA_W = 32;
	localparam int REG_W  = 8;
	localparam int IDX_W  = 16;

	// ==========================================================
	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_CAPTURE_VALUE  = 16'hFF86;
	localparam logic [IDX_W-1:0] IDX_INT_ENABLE     = 16'hFFF4;
	localparam logic [IDX_W-1:0] IDX_TIMER_MODE     = 16'hFF80;
	localparam logic [IDX_W-1:0] IDX_INT_REQUEST    = 16'hFF81;
	localparam logic [IDX_W-1:0] IDX_PIN_FUNCTION   = 16'hFF82;

	// ==========================================================
	// Field positions
	localparam int BIT_OVF_HIGH    = 7;
	localparam int BIT_OVF_LOW     = 6;
	localparam int BIT_OVF_IE      = 5;
	localparam int BIT_EDGE_SEL    = 4;
	localparam int BIT_CLR_HI      = 3;
	localparam int BIT_CLR_LO      = 2;
	localparam int BIT_CKS_HI      = 1;
	localparam int BIT_CKS_LO      = 0;
	localparam int BIT_TIMER_IRQ   = 4;
	localparam int BIT_PIN_CAPTURE = 0;

	// ==========================================================
	// Reset values and counter limits
	localparam logic [REG_W-1:0] COUNTER_RESET = 8'h00;
	localparam logic [REG_W-1:0] CAPTURE_RESET = 8'h00;
	localparam logic [REG_W-1:0] COUNTER_MAX   = 8'hFF;
	localparam logic [DATA_W-1:0] READ_ZERO    = 32'h00000000;

	// ==========================================================
	// Prescaler taps, as low bits that must all be one
	localparam int DIV64_BITS = 6;
	localparam int DIV32_BITS = 5;
	localparam int DIV2_BITS  = 1;

	// ==========================================================
	// Mode codes
	typedef enum logic [1:0] {
		CKS_DIV64 = 2'b00,
		CKS_DIV32 = 2'b01,
		CKS_DIV2  = 2'b10,
		CKS_STOP  = 2'b11
	} clock_sel_t;

	typedef enum logic [1:0] {
		CLR_NONE = 2'b00,
		CLR_FALL = 2'b01,
		CLR_RISE = 2'b10,
		CLR_BOTH = 2'b11
	} clear_sel_t;

endpackage

/* File: clock_prescaler.sv */
// Free-running prescaler counting every enabled system clock.
// Assumes one clock, synchronous active-low reset.
`timescale 1ns/1ps
module clock_prescaler #(
	parameter int WIDTH = 17
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	// Count
	output logic      [WIDTH-1:0] count
);
	// ==========================================================
	// Elaboration check: the slowest tap needs six bits
	if (WIDTH < capture_timer_pkg::DIV64_BITS) begin : g_bad_width
		$error("prescaler too narrow for the slowest tap");
	end

	logic [WIDTH-1:0] next_count;

	always_comb begin
		next_count = count;
		if (ce) begin
			next_count = count + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end
endmodule

/* File: input_capture_timer_period.sv */
// Eight-bit input-capture timer with APB register access.
// Assumes capture pin synchronous to clk; APB master per protocol.
//
// Notes on behaviour
// - High-level overflow flag, mode bit 7, sets on wrap while input high.
// - That flag clears only by writing 0 after reading 1; never set by writes.
// - Low-level overflow flag, bit 6, sets on wrap while low or interval.
// - Low flag clears only by writing 0 after reading 1; 1 ignored.
// - Mode bit 5 enables overflow interrupt requests.
// - Mode bit 4 picks interrupt edge: 0 rising, 1 falling.
// - Clear field bits 3:2: none, falling, rising, both edges.
// - Clock field bits 1:0: divide by 64, 32, 2.
// - Rising capture edge copies counter into capture register.
// - Rising capture with edge select 0 sets timer flag; enable gates output.
// - Capture register is read-only; writes ignored.
// - Capture register resets to zero.
// - Interrupt enable bit 4 gates the timer interrupt.
// - Request bit 4 set by capture or overflow, cleared by writing 0.
// - Pin function bit 0: 0 plain pin, 1 capture input.
// - Counter is hidden from software and resets to zero.
// - Wrap with overflow enable set raises timer flag.
// - Divided clocks come from a 17-bit free-running prescaler.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module input_capture_timer_period #(
	parameter int PRESCALE_W = 17
) (
	// Clock, reset, enable
	input  wire logic                                clk,
	input  wire logic                                rst_n,
	input  wire logic                                ce,
	// APB slave
	input  wire logic                                psel,
	input  wire logic                                penable,
	input  wire logic                                pwrite,
	input  wire logic [capture_timer_pkg::ADDR_W-1:0] paddr,
	input  wire logic [capture_timer_pkg::DATA_W-1:0] pwdata,
	output logic      [capture_timer_pkg::DATA_W-1:0] prdata,
	output logic                                     pready,
	output logic                                     pslverr,
	// Pin and interrupt
	input  wire logic                                port_pin_zero,
	output logic                                     timer_irq
);
	// ==========================================================
	// Elaboration check
	if (PRESCALE_W < capture_timer_pkg::DIV64_BITS) begin : g_bad_presc
		$error("prescaler width too small");
	end

	localparam int RW = capture_timer_pkg::REG_W;

	// ==========================================================
	// Prescaler
	logic [PRESCALE_W-1:0] presc;

	clock_prescaler #(
		.WIDTH (PRESCALE_W)
	) u_clock_prescaler (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.count (presc)
	);

	// ==========================================================
	// State
	logic [RW-1:0] capture_counter;
	logic [RW-1:0] capture_value;
	logic          overflow_high_flag;
	logic          overflow_low_flag;
	logic          overflow_irq_enable;
	logic          capture_edge_select;
	logic [1:0]    clear_select;
	logic [1:0]    clock_select;
	logic          timer_irq_enable;
	logic          timer_irq_flag;
	logic          pin_capture;
	logic          pin_prev;
	logic          armed_high;
	logic          armed_low;

	logic [RW-1:0] next_capture_counter;
	logic [RW-1:0] next_capture_value;
	logic          next_overflow_high_flag;
	logic          next_overflow_low_flag;
	logic          next_timer_irq_flag;
	logic          next_armed_high;
	logic          next_armed_low;
	logic [RW-1:0] next_mode_bits;
	logic          next_timer_irq_enable;
	logic          next_pin_capture;

	// ==========================================================
	// Bus decode
	logic                                 access;
	logic                                 wr;
	logic                                 rd;
	logic [capture_timer_pkg::IDX_W-1:0]  idx;
	logic                                 aligned;
	logic                                 hit_capture;
	logic                                 hit_enable;
	logic                                 hit_mode;
	logic                                 hit_request;
	logic                                 hit_pin;
	logic                                 hit_any;
	logic [RW-1:0]                        mode_reg;
	logic [capture_timer_pkg::DATA_W-1:0] read_mux;

	assign idx         = paddr[capture_timer_pkg::ADDR_W-1:2];
	assign aligned     = (paddr[1:0] == 2'h0);
	assign hit_capture = aligned && idx == capture_timer_pkg::IDX_CAPTURE_VALUE;
	assign hit_enable  = aligned && idx == capture_timer_pkg::IDX_INT_ENABLE;
	assign hit_mode    = aligned && idx == capture_timer_pkg::IDX_TIMER_MODE;
	assign hit_request = aligned && idx == capture_timer_pkg::IDX_INT_REQUEST;
	assign hit_pin     = aligned && idx == capture_timer_pkg::IDX_PIN_FUNCTION;
	assign hit_any     = hit_capture | hit_enable | hit_mode | hit_request
		| hit_pin;
	// Zero wait states; a frozen block holds the master off
	assign pready      = ce;
	assign access      = psel && penable && ce;
	assign wr          = access && pwrite;
	assign rd          = access && !pwrite;
	assign pslverr     = psel && penable && !hit_any;

	assign mode_reg = {overflow_high_flag, overflow_low_flag,
		overflow_irq_enable, capture_edge_select, clear_select,
		clock_select};

	always_comb begin
		read_mux = capture_timer_pkg::READ_ZERO;
		if (hit_capture) begin
			read_mux[RW-1:0] = capture_value;
		end else if (hit_enable) begin
			read_mux[capture_timer_pkg::BIT_TIMER_IRQ] = timer_irq_enable;
		end else if (hit_mode) begin
			read_mux[RW-1:0] = mode_reg;
		end else if (hit_request) begin
			read_mux[capture_timer_pkg::BIT_TIMER_IRQ] = timer_irq_flag;
		end else if (hit_pin) begin
			read_mux[capture_timer_pkg::BIT_PIN_CAPTURE] = pin_capture;
		end
	end

	// Read data latched in setup so it leaves a flip-flop
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prdata <= capture_timer_pkg::READ_ZERO;
		end else if (ce && psel && !penable) begin
			prdata <= read_mux;
		end
	end

	// ==========================================================
	// Edge detection and counter events
	logic cap_in;
	logic rise;
	logic fall;
	logic tick;
	logic clear_now;
	logic wrap;

	// Edges of a single sample apart; narrower pulses may be missed
	assign cap_in = pin_capture && port_pin_zero;
	assign rise   = ce && pin_capture && port_pin_zero && !pin_prev;
	assign fall   = ce && pin_capture && !port_pin_zero && pin_prev;

	always_comb begin
		case (capture_timer_pkg::clock_sel_t'(clock_select))
			capture_timer_pkg::CKS_DIV64:
				tick = &presc[capture_timer_pkg::DIV64_BITS-1:0];
			capture_timer_pkg::CKS_DIV32:
				tick = &presc[capture_timer_pkg::DIV32_BITS-1:0];
			capture_timer_pkg::CKS_DIV2:
				tick = &presc[capture_timer_pkg::DIV2_BITS-1:0];
			default:
				tick = 1'b0;
		endcase
	end

	always_comb begin
		case (capture_timer_pkg::clear_sel_t'(clear_select))
			capture_timer_pkg::CLR_FALL: clear_now = fall;
			capture_timer_pkg::CLR_RISE: clear_now = rise;
			capture_timer_pkg::CLR_BOTH: clear_now = rise || fall;
			default:                     clear_now = 1'b0;
		endcase
	end

	// Clearing beats counting, so a cleared cycle never wraps
	assign wrap = ce && tick && !clear_now
		&& capture_counter == capture_timer_pkg::COUNTER_MAX;

	// ==========================================================
	// Next state
	always_comb begin
		next_capture_counter    = capture_counter;
		next_capture_value      = capture_value;
		next_overflow_high_flag = overflow_high_flag;
		next_overflow_low_flag  = overflow_low_flag;
		next_timer_irq_flag     = timer_irq_flag;
		next_armed_high         = armed_high;
		next_armed_low          = armed_low;
		next_mode_bits          = mode_reg;
		next_timer_irq_enable   = timer_irq_enable;
		next_pin_capture        = pin_capture;

		if (clear_now) begin
			next_capture_counter = capture_timer_pkg::COUNTER_RESET;
		end else if (ce && tick) begin
			next_capture_counter = capture_counter + 1'b1;
		end

		if (rise) begin
			next_capture_value = capture_counter;
		end

		// Arm the clear only on a read that returned a one
		if (rd && hit_mode) begin
			next_armed_high = prdata[capture_timer_pkg::BIT_OVF_HIGH];
			next_armed_low  = prdata[capture_timer_pkg::BIT_OVF_LOW];
		end

		if (wr && hit_mode) begin
			next_mode_bits[capture_timer_pkg::BIT_OVF_IE:0] =
				pwdata[capture_timer_pkg::BIT_OVF_IE:0];
			next_armed_high = 1'b0;
			next_armed_low  = 1'b0;
			if (armed_high && !pwdata[capture_timer_pkg::BIT_OVF_HIGH]) begin
				next_overflow_high_flag = 1'b0;
			end
			if (armed_low && !pwdata[capture_timer_pkg::BIT_OVF_LOW]) begin
				next_overflow_low_flag = 1'b0;
			end
		end
		if (wr && hit_request && !pwdata[capture_timer_pkg::BIT_TIMER_IRQ]) begin
			next_timer_irq_flag = 1'b0;
		end
		if (wr && hit_enable) begin
			next_timer_irq_enable =
				pwdata[capture_timer_pkg::BIT_TIMER_IRQ];
		end
		if (wr && hit_pin) begin
			next_pin_capture = pwdata[capture_timer_pkg::BIT_PIN_CAPTURE];
		end

		// Hardware sets win over a clear in the same cycle
		if (wrap && cap_in) begin
			next_overflow_high_flag = 1'b1;
		end
		if (wrap && !cap_in) begin
			next_overflow_low_flag = 1'b1;
		end
		if ((rise && !capture_edge_select) || (fall && capture_edge_select))
		begin
			next_timer_irq_flag = 1'b1;
		end
		if (wrap && overflow_irq_enable) begin
			next_timer_irq_flag = 1'b1;
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			capture_counter     <= capture_timer_pkg::COUNTER_RESET;
			capture_value       <= capture_timer_pkg::CAPTURE_RESET;
			overflow_high_flag  <= 1'b0;
			overflow_low_flag   <= 1'b0;
			overflow_irq_enable <= 1'b0;
			capture_edge_select <= 1'b0;
			clear_select        <= 2'h0;
			clock_select        <= 2'h0;
			timer_irq_enable    <= 1'b0;
			timer_irq_flag      <= 1'b0;
			pin_capture         <= 1'b0;
			pin_prev            <= 1'b0;
			armed_high          <= 1'b0;
			armed_low           <= 1'b0;
		end else if (ce) begin
			capture_counter     <= next_capture_counter;
			capture_value       <= next_capture_value;
			overflow_high_flag  <= next_overflow_high_flag;
			overflow_low_flag   <= next_overflow_low_flag;
			overflow_irq_enable <= next_mode_bits[capture_timer_pkg::BIT_OVF_IE];
			capture_edge_select <=
				next_mode_bits[capture_timer_pkg::BIT_EDGE_SEL];
			clear_select        <= next_mode_bits[capture_timer_pkg::BIT_CLR_HI:
				capture_timer_pkg::BIT_CLR_LO];
			clock_select        <= next_mode_bits[capture_timer_pkg::BIT_CKS_HI:
				capture_timer_pkg::BIT_CKS_LO];
			timer_irq_enable    <= next_timer_irq_enable;
			timer_irq_flag      <= next_timer_irq_flag;
			pin_capture         <= next_pin_capture;
			pin_prev            <= port_pin_zero;
			armed_high          <= next_armed_high;
			armed_low           <= next_armed_low;
		end
	end

	assign timer_irq = timer_irq_flag && timer_irq_enable;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	capture_load_a: assert property (rise |=> capture_value == $past(capture_counter))
		else $error("capture register missed counter value");
	capture_ro_a: assert property (wr && hit_capture && !rise |=> $stable(capture_value))
		else $error("write changed capture register");
	ovf_high_set_a: assert property (wrap && cap_in |=> overflow_high_flag)
		else $error("high overflow flag not set");
	ovf_low_set_a: assert property (wrap && !cap_in |=> overflow_low_flag)
		else $error("low overflow flag not set");
	ovf_high_hold_a: assert property (!overflow_high_flag && !wrap |=> !overflow_high_flag)
		else $error("high overflow flag set without wrap");
	ovf_low_keep_a: assert property (overflow_low_flag && !armed_low |=> overflow_low_flag)
		else $error("low overflow flag cleared without read");
	ovf_irq_a: assert property (wrap && overflow_irq_enable |=> timer_irq_flag ##0 (timer_irq == timer_irq_enable))
		else $error("overflow did not raise timer flag");
	edge_irq_a: assert property (rise && !capture_edge_select |=> timer_irq_flag)
		else $error("rising capture did not raise timer flag");
	counter_clear_a: assert property (clear_now |=> capture_counter == capture_timer_pkg::COUNTER_RESET)
		else $error("counter not cleared on selected edge");
	counter_stop_a: assert property (clock_select == capture_timer_pkg::CKS_STOP && !clear_now |=> $stable(capture_counter))
		else $error("counter moved while stopped");
	div2_step_a: assert property (ce && clock_select == capture_timer_pkg::CKS_DIV2 && !clear_now && wr == 1'b0 ##1 ce && !clear_now |=> capture_counter != $past(capture_counter, 2))
		else $error("divide-by-two counter did not advance");

	capture_seen_c: cover property (rise ##1 capture_value != capture_timer_pkg::CAPTURE_RESET);
	ovf_high_c: cover property (wrap && cap_in ##1 overflow_high_flag);
	irq_out_c: cover property (timer_irq);
	flag_clear_c: cover property (overflow_low_flag ##[1:20] !overflow_low_flag);
endmodule

/* File: pulse_source.sv */
// Model of the pulse source that drives the capture pin.
// Assumes level widths in system clocks; holds idle level when stopped.
`timescale 1ns/1ps
module pulse_source (
	// Clock
	input  wire logic        clk,
	// Control
	input  wire logic        run,
	input  wire logic        idle,
	input  wire logic [15:0] hi_len,
	input  wire logic [15:0] lo_len,
	input  wire logic [15:0] min_len,
	// Pin
	output logic             pin
);
	// ==========================================================
	// Level timing
	logic [15:0] cnt;
	logic [15:0] want;
	logic [15:0] len;
	initial begin
		pin = 1'b0;
		cnt = 16'h0000;
	end
	assign want = pin ? hi_len : lo_len;
	// Shorter levels would make the capture unreliable
	assign len = (want < min_len) ? min_len : want;
	always @(posedge clk) begin
		if (!run) begin
			pin <= idle;
			cnt <= 16'h0000;
		end else if (cnt + 16'h0001 >= len) begin
			pin <= ~pin;
			cnt <= 16'h0000;
		end else begin
			cnt <= cnt + 16'h0001;
		end
	end
endmodule

/* File: input_capture_timer_period_test.sv */
// Self-checking bench for the capture timer, against a cycle model.
// Assumes the timer package and the pulse source model.
`timescale 1ns/1ps
module input_capture_timer_period_test;
	// ==========================================================
	// Signals and model state
	logic        clk;
	logic        rst_n;
	logic        ce;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [17:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pin;
	logic        timer_irq;
	logic        run;
	logic        idle;
	logic [15:0] hi_len;
	logic [15:0] lo_len;
	logic [15:0] min_len;
	logic [7:0]  cnt, cap, mode, nm;
	logic        en, req, pf, prev, arm_h, arm_l;
	logic        rise, fall, tick, clr, wrap, nr;
	int          psc, dv;
	int          n_mismatch = 0;
	int          n_tests = 0;
	int          seed = 32'hE183;
	localparam logic [17:0] A_MODE =
		{capture_timer_pkg::IDX_TIMER_MODE, 2'b00};
	localparam logic [17:0] A_CAP =
		{capture_timer_pkg::IDX_CAPTURE_VALUE, 2'b00};
	localparam logic [17:0] A_EN =
		{capture_timer_pkg::IDX_INT_ENABLE, 2'b00};
	localparam logic [17:0] A_REQ =
		{capture_timer_pkg::IDX_INT_REQUEST, 2'b00};
	localparam logic [17:0] A_PF =
		{capture_timer_pkg::IDX_PIN_FUNCTION, 2'b00};
	logic [17:0] regs [5] = '{A_MODE, A_CAP, A_EN, A_REQ, A_PF};

	input_capture_timer_period DUT (.clk(clk), .rst_n(rst_n), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .port_pin_zero(pin), .timer_irq(timer_irq));
	pulse_source src (.clk(clk), .run(run), .idle(idle), .hi_len(hi_len),
		.lo_len(lo_len), .min_len(min_len), .pin(pin));

	// ==========================================================
	// Cycle model
	always @(posedge clk) begin
		if (!rst_n) begin
			psc <= 0;
			cnt <= 8'h00;
			cap <= 8'h00;
			mode <= 8'h00;
			{en, req, pf, prev, arm_h, arm_l} <= 6'h00;
		end else if (ce) begin
			rise = pin & ~prev & pf;
			fall = ~pin & prev & pf;
			dv = mode[1] ? 2 : mode[0] ? 32 : 64;
			tick = mode[1:0] != 2'b11 && psc % dv == dv - 1;
			clr = (fall & mode[2]) | (rise & mode[3]);
			wrap = tick & ~clr & (cnt == 8'hFF);
			nm = mode;
			nr = req;
			if (psel & penable & pwrite) begin
				if (paddr == A_MODE) begin
					nm[5:0] = pwdata[5:0];
					if (arm_h & ~pwdata[7]) nm[7] = 1'b0;
					if (arm_l & ~pwdata[6]) nm[6] = 1'b0;
					{arm_h, arm_l} <= 2'b00;
				end
				if (paddr == A_REQ && !pwdata[4]) nr = 1'b0;
				if (paddr == A_EN) en <= pwdata[4];
				if (paddr == A_PF) pf <= pwdata[0];
			end else if (psel & ~penable & ~pwrite & paddr == A_MODE) begin
				arm_h <= arm_h | mode[7];
				arm_l <= arm_l | mode[6];
			end
			if (wrap & pin & pf) nm[7] = 1'b1;
			if (wrap & ~(pin & pf)) nm[6] = 1'b1;
			if ((wrap & mode[5]) | (rise & ~mode[4]) | (fall & mode[4]))
				nr = 1'b1;
			if (rise) cap <= cnt;
			cnt <= clr ? 8'h00 : tick ? cnt + 8'h01 : cnt;
			psc <= (psc + 1) % 131072;
			prev <= pin;
			mode <= nm;
			req <= nr;
		end
	end

	function automatic logic [32:0] exp_rd(input logic [17:0] a);
		case (a)
			A_MODE: return {25'h0000000, mode};
			A_CAP: return {25'h0000000, cap};
			A_EN: return {28'h0000000, en, 4'h0};
			A_REQ: return {28'h0000000, req, 4'h0};
			A_PF: return {32'h00000000, pf};
			default: return {1'b1, 32'h00000000};
		endcase
	endfunction

	// ==========================================================
	// Checks and bus tasks
	task automatic chk(string nm_s, logic [31:0] e, logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm_s, e, g);
			n_mismatch++;
		end
	endtask

	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic apb(logic wr, logic [17:0] a, logic [31:0] d);
		logic [32:0] e;
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		e = exp_rd(a);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_mismatch++;
			wrap_up();
		end
		chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
		if (!wr) chk("prdata", e[31:0], prdata);
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge so the next setup never rewrites psel in this step
		@(posedge clk);
	endtask

	always @(negedge clk)
		if (rst_n === 1'b1) begin
			chk("timer_irq", 32'(req & en), 32'(timer_irq));
			chk("pready", 32'(ce), 32'(pready));
		end

	// ==========================================================
	// Stimulus
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		repeat (100000) @(posedge clk);
		n_mismatch++;
		wrap_up();
	end

	initial begin
		{rst_n, psel, penable, pwrite, run, idle} = 6'h00;
		ce = 1'b1;
		paddr = 18'h00000;
		pwdata = 32'h00000000;
		{hi_len, lo_len, min_len} = 48'h000400040004;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		foreach (regs[i]) apb(1'b0, regs[i], 32'h0);
		apb(1'b0, 18'h00004, 32'h0);
		apb(1'b1, A_MODE | 18'h00001, 32'h000000FF);
		apb(1'b1, A_PF, 32'h00000001);
		apb(1'b1, A_EN, 32'h00000010);
		for (int k = 0; k < 16; k++) begin
			apb(1'b1, A_MODE, {27'h0, k[0] ^ k[3], k[3:0]});
			min_len <= k[1] ? 16'h0004 : k[0] ? 16'h0040 : 16'h0080;
			hi_len <= 16'($random(seed) & 255);
			lo_len <= 16'($random(seed) & 255);
			run <= 1'b1;
			if (k == 5) begin
				ce <= 1'b0;
				repeat (37) @(posedge clk);
				ce <= 1'b1;
			end
			repeat (4) begin
				repeat (100 + ($random(seed) & 511)) @(posedge clk);
				apb(1'b0, A_CAP, 32'h0);
				apb(1'b0, A_REQ, 32'h0);
				apb(1'b1, A_REQ, 32'h00000000);
			end
		end
		run <= 1'b0;
		idle <= 1'b1;
		apb(1'b1, A_CAP, 32'h000000A5);
		apb(1'b0, A_CAP, 32'h0);
		apb(1'b1, A_MODE, 32'h00000022);
		repeat (600) @(posedge clk);
		apb(1'b1, A_MODE, 32'h00000022);
		apb(1'b0, A_MODE, 32'h0);
		apb(1'b1, A_MODE, 32'h000000C2);
		apb(1'b0, A_MODE, 32'h0);
		apb(1'b1, A_MODE, 32'h00000002);
		apb(1'b0, A_REQ, 32'h0);
		apb(1'b1, A_REQ, 32'h00000010);
		apb(1'b0, A_REQ, 32'h0);
		apb(1'b1, A_REQ, 32'h00000000);
		apb(1'b1, A_PF, 32'h00000000);
		repeat (600) @(posedge clk);
		apb(1'b0, A_MODE, 32'h0);
		apb(1'b1, A_MODE, 32'h00000082);
		apb(1'b0, A_MODE, 32'h0);
		apb(1'b0, A_REQ, 32'h0);
		wrap_up();
	end
endmodule
